// [bench/spir_chk.sv]
`timescale 1ns/1ps
module spir_chk #(parameter STAGES = 12) (
    input wire CLK_I, RST_N_I, WR_I, RD_I,
    input wire [9:0] ADDR_I,
    input wire [15:0] WDATA_I, RDATA_O,
    input wire [11:0] NEAR_SET_I, NEAR_CLR_I,
    input wire [3:0] STAGE_I,
    input wire [12:0] ROUTE_NEG_O, ROUTE_POS_O, ROUTE_BIAS_O
);
    wire rp = RD_I && ADDR_I == 10'h042;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    hold_rd_a: assert property (!RD_I |=> $stable(RDATA_O)) else $error("hold");
    flag_set_a: assert property (NEAR_SET_I[0] ##1 !NEAR_CLR_I[0] ##1 rp |=> RDATA_O[0])
        else $error("flag");
    flag_top_a: assert property (rp |=> RDATA_O[15:12] == 0) else $error("top");
    unmap_rd_a: assert property (RD_I && ADDR_I == 10'h3FF |=> RDATA_O == 0)
        else $error("unmapped");
    hi_top_a: assert property (RD_I && ADDR_I == 10'h0D9 |=> RDATA_O[15:12] == 0)
        else $error("hi top");
    wr_back_a: assert property (WR_I && ADDR_I == 10'h0D8 ##2 RD_I && ADDR_I == 10'h0D8
        |=> RDATA_O == ($past(WDATA_I, 3) & 16'h3FFF)) else $error("readback");
    bad_stage_a: assert property (STAGE_I > 11 |=> !(ROUTE_NEG_O | ROUTE_POS_O | ROUTE_BIAS_O))
        else $error("stage");
    one_node_a: assert property (!(ROUTE_NEG_O & ROUTE_POS_O) &&
        !(ROUTE_BIAS_O & (ROUTE_NEG_O | ROUTE_POS_O))) else $error("exclusive");
endmodule
bind spir_top spir_chk #(.STAGES(STAGES)) u_spir_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
    .WR_I(WR_I), .RD_I(RD_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O),
    .NEAR_SET_I(NEAR_SET_I), .NEAR_CLR_I(NEAR_CLR_I), .STAGE_I(STAGE_I),
    .ROUTE_NEG_O(ROUTE_NEG_O), .ROUTE_POS_O(ROUTE_POS_O), .ROUTE_BIAS_O(ROUTE_BIAS_O));

// [bench/spir_host.sv]
`timescale 1ns/1ps
module spir_host (
    input wire clk_i,
    input wire [15:0] rdata_i,
    output logic [9:0] addr_o = 0,
    output logic wr_o = 0,
    output logic rd_o = 0,
    output logic [15:0] wdata_o = 0
);
    // Callers keep spare bits zero and leave spare inputs open
    task wr_w(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1;
        @(posedge clk_i);
        addr_o <= ~a;
        wdata_o <= ~d;
        wr_o <= 0;
    endtask
    task rd_w(input logic [9:0] a, output logic [15:0] q);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1;
        @(posedge clk_i);
        addr_o <= ~a;
        rd_o <= 0;
        #1 q = rdata_i;
    endtask
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic CLK_I = 0;
    logic RST_N_I = 0;
    logic [11:0] set_p = 0;
    logic [11:0] clr_p = 0;
    logic [3:0] stage = 0;
    logic [9:0] addr;
    logic wr, rd;
    logic [15:0] wd, rdat, q;
    logic [12:0] neg, pos, bias;
    int num_errors = 0;
    int tests_run = 0;
    always #12.5 CLK_I = ~CLK_I;
    spir_top u_spir_top (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(addr), .WR_I(wr),
        .RD_I(rd), .WDATA_I(wd), .RDATA_O(rdat), .NEAR_SET_I(set_p), .NEAR_CLR_I(clr_p),
        .STAGE_I(stage), .ROUTE_NEG_O(neg), .ROUTE_POS_O(pos), .ROUTE_BIAS_O(bias));
    spir_host u_spir_host (.clk_i(CLK_I), .rdata_i(rdat), .addr_o(addr), .wr_o(wr),
        .rd_o(rd), .wdata_o(wd));
    task chk(input logic [15:0] g, e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %0t %h", $time, g);
        end
    endtask
    task chk_route(input logic [12:0] g, e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %0t route %h", $time, g);
        end
    endtask
    task rc(input logic [9:0] a, input logic [15:0] e);
        u_spir_host.rd_w(a, q);
        chk(q, e);
    endtask
    // Matrix is registered, so give it two edges to follow the stage
    task rt(input logic [3:0] s, input logic [12:0] n, p, b);
        @(posedge CLK_I) stage <= s;
        repeat (2) @(posedge CLK_I);
        #1 chk_route(neg, n);
        chk_route(pos, p);
        chk_route(bias, b);
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge CLK_I);
        RST_N_I <= 1;
        rc(10'h042, 16'h0000);
        @(posedge CLK_I) set_p <= 12'hFFF;
        @(posedge CLK_I) set_p <= 0;
        rc(10'h042, 16'h0FFF);
        @(posedge CLK_I) {set_p, clr_p} <= {12'h001, 12'h003};
        @(posedge CLK_I) {set_p, clr_p} <= 0;
        u_spir_host.wr_w(10'h042, 16'h0000);
        rc(10'h042, 16'h0FFD);
        u_spir_host.wr_w(10'h0D9, 16'h0FE4);
        u_spir_host.wr_w(10'h0D8, 16'h1BE4);
        rc(10'h0D8, 16'h1BE4);
        rc(10'h0D9, 16'h0FE4);
        rc(10'h3FF, 16'h0000);
        rc(10'h080, 16'h0000);
        rt(11, 13'h0142, 13'h0224, 13'h1C18);
        rt(15, 13'h0000, 13'h0000, 13'h0000);
        u_spir_host.wr_w(10'h080, 16'h0006);
        rc(10'h080, 16'h0006);
        rt(0, 13'h0002, 13'h0001, 13'h0000);
        report_and_stop;
    end
endmodule

// [verilog/spir_consts.vh]
`ifndef SPIR_CONSTS_VH
`define SPIR_CONSTS_VH
// ==========================================================
// Register map
`define SPIR_ADDR_W 10
`define SPIR_PROX_ADDR 10'h042
// Routing block base: stage s low word at base + 8*s (bank 2)
`define SPIR_ROUTE_BASE 10'h080
`define SPIR_ROUTE_STRIDE_SH 3
// Upper routing word sits at stage base + 1
`define SPIR_ROUTE_HI_OFS 10'h001
// ==========================================================
// Field layout and reset values
`define SPIR_STAGES 12
`define SPIR_INPUTS_LO 7
`define SPIR_INPUTS_HI 6
`define SPIR_PROX_RESET 16'h0000
`define SPIR_ROUTE_RESET 16'h0000
`define SPIR_FLAG_RESET 12'h000
`define SPIR_ROUTE_LO_RESET 14'h0000
`define SPIR_ROUTE_HI_RESET 12'h000
// ==========================================================
// Route selection codes
`define SPIR_SEL_OPEN 2'b00
`define SPIR_SEL_NEG 2'b01
`define SPIR_SEL_POS 2'b10
`define SPIR_SEL_BIAS 2'b11
`endif

// [verilog/spir_top.v]
// Function
// - Proximity word at address 0x042, bit per stage
// - Flags bits 0..11, read-only, zero after reset
// - Twelve stages each own lower routing register
// - Code 00 leaves input disconnected
// - Code 01 routes input to negative side
// - Code 10 routes input to positive side
// - Code 11 ties input to bias
// - Input n field at bits 2n+1:2n
// - Inputs 7 up in upper register, same code
`timescale 1ns/1ps
`include "spir_consts.vh"

module spir_top #(
    parameter STAGES = `SPIR_STAGES
) (
    input wire CLK_I,                            // 40 MHz clock
    input wire RST_N_I,                          // Sync reset, active low
    input wire [`SPIR_ADDR_W-1:0] ADDR_I,        // Register address
    input wire WR_I,                             // Write strobe
    input wire RD_I,                             // Read strobe
    input wire [15:0] WDATA_I,                   // Write data
    output reg [15:0] RDATA_O,                   // Read data, registered
    input wire [`SPIR_STAGES-1:0] NEAR_SET_I,    // Detector set pulses
    input wire [`SPIR_STAGES-1:0] NEAR_CLR_I,    // Detector clear pulses
    input wire [3:0] STAGE_I,                    // Stage being converted
    output reg [12:0] ROUTE_NEG_O,               // Inputs on negative node
    output reg [12:0] ROUTE_POS_O,               // Inputs on positive node
    output reg [12:0] ROUTE_BIAS_O               // Inputs tied to bias
);

    // ==========================================================
    // Storage
    localparam INPUTS = `SPIR_INPUTS_LO + `SPIR_INPUTS_HI;

    reg [11:0] stage_near_detect_flag_reg;
    reg [15:0] rdata_next;
    reg [25:0] sel_word;
    wire [14*STAGES-1:0] route_lo_bus;
    wire [12*STAGES-1:0] route_hi_bus;
    wire [16*STAGES-1:0] rd_term_bus;
    wire [12:0] neg_next;
    wire [12:0] pos_next;
    wire [12:0] bias_next;
    integer k;
    integer j;

    // ==========================================================
    // Proximity flags
    // Set wins over clear so no detection is lost
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            stage_near_detect_flag_reg <= `SPIR_FLAG_RESET;
        end else begin
            stage_near_detect_flag_reg <= NEAR_SET_I |
                (stage_near_detect_flag_reg & ~NEAR_CLR_I);
        end
    end

    // ==========================================================
    // Per-stage routing registers
    // One register pair per stage keeps each flop with one driver
    genvar s;
    generate
        for (s = 0; s < STAGES; s = s + 1) begin : g_stage
            // Address sums are worked out wide, then cut to the bus
            localparam [31:0] LO_FULL = `SPIR_ROUTE_BASE + (s << `SPIR_ROUTE_STRIDE_SH);
            localparam [31:0] HI_FULL = LO_FULL + `SPIR_ROUTE_HI_OFS;

            wire [`SPIR_ADDR_W-1:0] lo_addr;
            wire [`SPIR_ADDR_W-1:0] hi_addr;
            wire lo_hit;
            wire hi_hit;
            reg [13:0] lo_reg;
            reg [11:0] hi_reg;

            assign lo_addr = LO_FULL[`SPIR_ADDR_W-1:0];
            assign hi_addr = HI_FULL[`SPIR_ADDR_W-1:0];
            assign lo_hit = (ADDR_I == lo_addr);
            assign hi_hit = (ADDR_I == hi_addr);

            always @(posedge CLK_I) begin
                if (!RST_N_I) begin
                    lo_reg <= `SPIR_ROUTE_LO_RESET;
                    hi_reg <= `SPIR_ROUTE_HI_RESET;
                end else begin
                    if (WR_I && lo_hit) begin
                        lo_reg <= WDATA_I[13:0];
                    end
                    if (WR_I && hi_hit) begin
                        hi_reg <= WDATA_I[11:0];
                    end
                end
            end

            assign route_lo_bus[14*s +: 14] = lo_reg;
            assign route_hi_bus[12*s +: 12] = hi_reg;

            // Spare top bits are not stored, so they read as zero
            assign rd_term_bus[16*s +: 16] = lo_hit ? {2'b00, lo_reg} :
                (hi_hit ? {4'h0, hi_reg} : 16'h0000);
        end
    endgenerate

    // ==========================================================
    // Read mux
    // Proximity word has no write path, so host writes are dropped
    always @* begin
        rdata_next = 16'h0000;
        if (ADDR_I == `SPIR_PROX_ADDR) begin
            rdata_next = {4'h0, stage_near_detect_flag_reg};
        end
        for (k = 0; k < STAGES; k = k + 1) begin
            rdata_next = rdata_next | rd_term_bus[16*k +: 16];
        end
    end

    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            RDATA_O <= 16'h0000;
        end else if (RD_I) begin
            RDATA_O <= rdata_next;
        end
    end

    // ==========================================================
    // Active stage selection
    // Out-of-range stage numbers select nothing, all inputs open
    always @* begin
        sel_word = 26'h0000_000;
        for (j = 0; j < STAGES; j = j + 1) begin
            if (STAGE_I == j[3:0]) begin
                sel_word = {route_hi_bus[12*j +: 12], route_lo_bus[14*j +: 14]};
            end
        end
    end

    // ==========================================================
    // Switch matrix decode, one slice per sensor input
    genvar n;
    generate
        for (n = 0; n < INPUTS; n = n + 1) begin : g_input
            wire [1:0] input_route_select;
            reg neg_bit;
            reg pos_bit;
            reg bias_bit;

            assign input_route_select = sel_word[2*n +: 2];

            always @* begin
                neg_bit = 1'b0;
                pos_bit = 1'b0;
                bias_bit = 1'b0;
                case (input_route_select)
                    `SPIR_SEL_OPEN: begin
                        neg_bit = 1'b0;
                        pos_bit = 1'b0;
                        bias_bit = 1'b0;
                    end
                    `SPIR_SEL_NEG: begin
                        neg_bit = 1'b1;
                    end
                    `SPIR_SEL_POS: begin
                        pos_bit = 1'b1;
                    end
                    `SPIR_SEL_BIAS: begin
                        bias_bit = 1'b1;
                    end
                    default: begin
                        neg_bit = 1'b0;
                    end
                endcase
            end

            assign neg_next[n] = neg_bit;
            assign pos_next[n] = pos_bit;
            assign bias_next[n] = bias_bit;
        end
    endgenerate

    // ==========================================================
    // Registered switch outputs
    // Registered so the matrix never sees decode glitches
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ROUTE_NEG_O <= 13'h0000;
            ROUTE_POS_O <= 13'h0000;
            ROUTE_BIAS_O <= 13'h0000;
        end else begin
            ROUTE_NEG_O <= neg_next;
            ROUTE_POS_O <= pos_next;
            ROUTE_BIAS_O <= bias_next;
        end
    end

endmodule
